// [rtl/bde_pkg.sv]
// Purpose: Shared constants and types for the buzzer duty/envelope block
// Assumes: 250 MHz system clock, 32.768 kHz nominal low-speed oscillator
// Notes:   Register indices are word indices; byte address is index * 4
package bde_pkg;

  // Clock and oscillator rates
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned OSC_HZ = 32_768;
  // Fine tone grain runs at twice the oscillator rate
  localparam int unsigned TICK_HZ = 2 * OSC_HZ;
  // System cycles per tone grain, rounded down
  localparam int unsigned TICK_DIV = CLK_HZ / TICK_HZ;

  // Interval times in microseconds, as nominal figures
  localparam longint unsigned REL_LONG_US = 125_000;
  localparam longint unsigned REL_SHORT_US = 62_500;
  localparam longint unsigned BURST_LONG_US = 125_000;
  localparam longint unsigned BURST_SHORT_US = 31_250;

  // Interval lengths in tone grains
  localparam logic [13:0] REL_LONG_TICKS =
    14'(REL_LONG_US * TICK_HZ / 1_000_000);
  localparam logic [13:0] REL_SHORT_TICKS =
    14'(REL_SHORT_US * TICK_HZ / 1_000_000);
  localparam logic [13:0] BURST_LONG_TICKS =
    14'(BURST_LONG_US * TICK_HZ / 1_000_000);
  localparam logic [13:0] BURST_SHORT_TICKS =
    14'(BURST_SHORT_US * TICK_HZ / 1_000_000);

  // Duty levels: 0 is maximum, 7 is minimum
  localparam logic [2:0] LVL_MAX = 3'h0;
  localparam logic [2:0] LVL_MIN = 3'h7;

  // Tone period and high-count bases in grains
  localparam logic [4:0] PER_BASE = 5'h10;
  localparam logic [4:0] HIGH_SHORT = 5'h08;
  localparam logic [4:0] HIGH_LONG = 5'h0c;

  // Register word indices
  localparam int ADDR_W = 18;
  localparam logic [15:0] IDX_ENV = 16'hff6c;
  localparam logic [15:0] IDX_SHOT = 16'hff6d;
  localparam logic [15:0] IDX_FREQ = 16'hff6e;
  localparam logic [15:0] IDX_DUTY = 16'hff6f;

  // envelope_control bit positions
  localparam int BIT_TONE_EN = 0;
  localparam int BIT_ENV_EN = 1;
  localparam int BIT_ENV_RESTART = 2;
  localparam int BIT_REL_SEL = 3;

  // oneshot_control bit positions
  localparam int BIT_WIDTH_SEL = 0;
  localparam int BIT_TRIGGER = 1;
  localparam int BIT_STOP = 2;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Envelope and tone control bits
  typedef struct packed {
    logic releaseSel;
    logic envEn;
    logic toneEn;
  } bde_ctl_s;

  localparam bde_ctl_s CTL_RST = '0;
  localparam logic [2:0] FREQ_RST = 3'h0;
  localparam logic [2:0] DUTY_RST = 3'h0;
  localparam logic WIDTH_RST = 1'b0;

endpackage

// [rtl/bde_tick_div.sv]
// Purpose: Divider giving a one-cycle enable every DIV clocks
// Assumes: Single clock, synchronous active-high reset
// Notes:   DIV of 1 gives an enable every cycle
`timescale 1ns/100ps
module bde_tick_div #(
  parameter int unsigned DIV = 4
) (
  input wire logic clock,
  input wire logic sys_rst,
  output logic tick
);
  localparam int W = $clog2(DIV + 1);
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  logic [W-1:0] cnt;

  // Count and emit the enable pulse
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cnt <= '0;
      tick <= 1'b0;
    end else if (cnt >= LAST) begin
      cnt <= '0;
      tick <= 1'b1;
    end else begin
      cnt <= cnt + W'(1);
      tick <= 1'b0;
    end
  end

  a_tick_spacing: assert property (@(posedge clock) disable iff (sys_rst)
    tick |=> !tick || (DIV == 1))
    else $error("tick pulses too close");

endmodule // bde_tick_div

// [rtl/bde_buzzer.sv]
// Purpose: Buzzer duty, decay envelope and one-shot burst, AXI4-Lite
// Assumes: AXI4-Lite master keeps one write and one read in flight
// Notes:   All tone timing comes from a grain at twice the oscillator
//
// Overview of operation
// - Short-period codes: level 0 gives 8 high grains, down to 1.
// - Long-period codes: level 0 gives 12 high grains, down to 5.
// - Duty field unused while envelope on; clears at reset.
// - Envelope restart returns to maximum unless envelope off and silent.
// - Envelope enable applies decay while tone sounds; clears at reset.
// - Envelope steps each 125 or 62.5 ms, seven steps total.
// - Burst width 125 or 31.25 ms; no effect on continuous tone.
// - Trigger write starts burst that ends itself after the width.
// - Trigger accepted only while continuous tone disabled.
// - Retrigger during burst restarts width timer.
// - Trigger bit reads busy during a burst; zero after reset.
// - Stop write ends running burst early; otherwise ignored; reads zero.
// - Tone phase runs free, so edges may truncate on enable changes.
// - All periods derive from divided oscillator grain.
// - Frequency code picks one of eight divided tone rates.
// - Tone enable or a running burst drives both outputs; otherwise both stay off.
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module bde_buzzer #(
  parameter int unsigned TICK_DIV = bde_pkg::TICK_DIV
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [bde_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [bde_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic tone_out,
  output logic tone_out_inverted
);
  import bde_pkg::*;

  // Default clock and reset for the checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  bde_ctl_s ctl;
  logic [2:0] toneFreqSel;
  logic [2:0] dutyLevelSel;
  logic burstWidthSel;
  logic awHeld, wHeld, wrStrb0;
  logic [15:0] wrIdx;
  logic [31:0] wrData;
  logic doWrite, wrHit, wrEnv, wrShot;
  logic restartReq, trigReq, stopReq;
  logic tick, halfTick, stepEn;
  logic burstBusy;
  logic [13:0] burstCnt, burstLimit;
  logic toneActive, activeDly, toneStart;
  logic [2:0] envLevel, dutyUsed;
  logic [13:0] relCnt, relLimit;
  logic [4:0] phase, period, highCnt;
  logic toneHigh;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;

  function automatic logic isMapped(input logic [15:0] idx);
    return idx == IDX_ENV || idx == IDX_SHOT ||
           idx == IDX_FREQ || idx == IDX_DUTY;
  endfunction

  bde_tick_div #(.DIV(TICK_DIV)) u_tick (
    .clock(clock),
    .sys_rst(sys_rst),
    .tick(tick)
  );

  // Write channel acceptance
  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready = !wHeld && !s_axi_bvalid;
  assign doWrite = awHeld && wHeld;
  assign wrHit = doWrite && wrStrb0 && isMapped(wrIdx);
  assign wrEnv = wrHit && wrIdx == IDX_ENV;
  assign wrShot = wrHit && wrIdx == IDX_SHOT;

  // Hold address and data until both present
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      wrIdx <= '0;
      wrData <= '0;
      wrStrb0 <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        wrIdx <= s_axi_awaddr[ADDR_W-1:2];
      end else if (doWrite) begin
        awHeld <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wrData <= s_axi_wdata;
        wrStrb0 <= s_axi_wstrb[0];
      end else if (doWrite) begin
        wHeld <= 1'b0;
      end
    end
  end

  // Write response
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= isMapped(wrIdx) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read mux; restart and stop bits read zero
  always_comb begin
    next_rdata = '0;
    next_rresp = RESP_OKAY;
    case (s_axi_araddr[ADDR_W-1:2])
      IDX_ENV: begin
        next_rdata[BIT_TONE_EN] = ctl.toneEn;
        next_rdata[BIT_ENV_EN] = ctl.envEn;
        next_rdata[BIT_REL_SEL] = ctl.releaseSel;
      end
      IDX_SHOT: begin
        next_rdata[BIT_WIDTH_SEL] = burstWidthSel;
        next_rdata[BIT_TRIGGER] = burstBusy;
      end
      IDX_FREQ: next_rdata[2:0] = toneFreqSel;
      IDX_DUTY: next_rdata[2:0] = dutyLevelSel;
      default: next_rresp = RESP_SLVERR;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  // Read data channel
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctl <= CTL_RST;
      toneFreqSel <= FREQ_RST;
      dutyLevelSel <= DUTY_RST;
      burstWidthSel <= WIDTH_RST;
    end else begin
      if (wrEnv) begin
        ctl.toneEn <= wrData[BIT_TONE_EN];
        ctl.envEn <= wrData[BIT_ENV_EN];
        ctl.releaseSel <= wrData[BIT_REL_SEL];
      end
      if (wrShot) burstWidthSel <= wrData[BIT_WIDTH_SEL];
      if (wrHit && wrIdx == IDX_FREQ) toneFreqSel <= wrData[2:0];
      if (wrHit && wrIdx == IDX_DUTY) dutyLevelSel <= wrData[2:0];
    end
  end

  // restart only if envelope on or tone sounding
  assign restartReq = wrEnv && wrData[BIT_ENV_RESTART] &&
                      (ctl.envEn || toneActive);
  // trigger refused while continuous tone enabled
  assign trigReq = wrShot && wrData[BIT_TRIGGER] && !ctl.toneEn;
  // stop only acts during a burst
  assign stopReq = wrShot && wrData[BIT_STOP] && burstBusy;
  assign burstLimit = burstWidthSel ? BURST_LONG_TICKS : BURST_SHORT_TICKS;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      burstBusy <= 1'b0;
      burstCnt <= '0;
    end else if (trigReq) begin
      burstBusy <= 1'b1;
      burstCnt <= '0;
    end else if (stopReq) begin
      burstBusy <= 1'b0;
    end else if (burstBusy && tick) begin
      if (burstCnt >= burstLimit - 14'h0001) begin
        burstBusy <= 1'b0;
      end else begin
        burstCnt <= burstCnt + 14'h0001;
      end
    end
  end

  // tone sounds on enable or burst
  assign toneActive = ctl.toneEn || burstBusy;
  assign toneStart = toneActive && !activeDly;

  // Tone start edge detect
  always_ff @(posedge clock) begin
    if (sys_rst) activeDly <= 1'b0;
    else activeDly <= toneActive;
  end

  assign relLimit = ctl.releaseSel ? REL_LONG_TICKS : REL_SHORT_TICKS;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      envLevel <= LVL_MAX;
      relCnt <= '0;
    end else if (restartReq || toneStart) begin
      envLevel <= LVL_MAX;
      relCnt <= '0;
    end else if (ctl.envEn && toneActive && tick) begin
      // one level per interval, hold at minimum
      if (relCnt >= relLimit - 14'h0001) begin
        relCnt <= '0;
        if (envLevel != LVL_MIN) envLevel <= envLevel + 3'h1;
      end else begin
        relCnt <= relCnt + 14'h0001;
      end
    end
  end

  assign dutyUsed = ctl.envEn ? envLevel : dutyLevelSel;

  // period 16..28 grains, slow half for codes 4..7
  assign period = PER_BASE + {1'b0, toneFreqSel[1:0], 2'b00};
  assign stepEn = tick && (!toneFreqSel[2] || halfTick);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      halfTick <= 1'b0;
      phase <= '0;
    end else if (tick) begin
      halfTick <= !halfTick;
      if (stepEn) begin
        if (phase >= period - 5'h01) phase <= '0;
        else phase <= phase + 5'h01;
      end
    end
  end

  // 8 down to 1 high grains
  // 12 down to 5 high grains
  assign highCnt = (toneFreqSel[1] ? HIGH_LONG : HIGH_SHORT) -
                   {2'b00, dutyUsed};
  assign toneHigh = phase < highCnt;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tone_out <= 1'b0;
      tone_out_inverted <= 1'b0;
    end else begin
      tone_out <= toneActive && toneHigh;
      tone_out_inverted <= toneActive && !toneHigh;
    end
  end

  a_off_idle: assert property (
    !toneActive |=> !tone_out && !tone_out_inverted)
    else $error("tone outputs active while tone disabled");

  a_pair_complement: assert property (
    toneActive |=> tone_out != tone_out_inverted)
    else $error("tone outputs not complementary");

  a_trig_blocked: assert property (
    wrShot && wrData[BIT_TRIGGER] && ctl.toneEn && !burstBusy
    |=> !burstBusy)
    else $error("burst started while tone enabled");

  a_trig_start: assert property (
    trigReq |=> burstBusy && burstCnt == 14'h0000)
    else $error("trigger did not start burst");

  a_stop_ends: assert property (
    stopReq && !trigReq |=> !burstBusy)
    else $error("stop did not end burst");

  a_width_expire: assert property (
    burstBusy && tick && !wrShot &&
    burstCnt == burstLimit - 14'h0001 |=> !burstBusy)
    else $error("burst outlived its width");

  a_env_restart: assert property (
    restartReq |=> envLevel == LVL_MAX && relCnt == 14'h0000)
    else $error("envelope restart ignored");

  a_env_step: assert property (
    $changed(envLevel) |->
      envLevel == LVL_MAX || envLevel == $past(envLevel) + 3'h1)
    else $error("envelope moved by more than one level");

  a_duty_select: assert property (
    ctl.envEn && $stable(ctl.envEn) && $stable(envLevel) &&
    $stable(toneFreqSel) |-> $stable(highCnt))
    else $error("software duty used under envelope");

  a_high_range: assert property (
    toneFreqSel[1] |-> highCnt >= 5'h05 && highCnt <= HIGH_LONG)
    else $error("long-period high count out of range");

  c_burst_done: cover property (burstBusy ##1 !burstBusy);
  c_env_floor: cover property (ctl.envEn && envLevel == LVL_MIN);
  c_retrigger: cover property (burstBusy && trigReq);

endmodule // bde_buzzer

// [testbench/bde_piezo.sv]
// Purpose: Piezo load model that times the tone pin pair
// Assumes: Pins are sampled on the system clock
// Notes:   Lengths are counted in system clock cycles
`timescale 1ns/100ps
module bde_piezo (
  input wire logic clock,
  input wire logic toneOut,
  input wire logic toneOutInv,
  output int hiLen,
  output int perLen,
  output logic clash
);
  int cnt = 0;
  logic last = 1'b0;

  // Start values before any tone
  initial begin
    hiLen = 0;
    perLen = 0;
    clash = 1'b0;
  end

  // High phase and full period of the true pin
  always @(posedge clock) begin
    cnt <= cnt + 1;
    last <= toneOut;
    if (toneOut && !last) begin
      perLen <= cnt;
      cnt <= 1;
    end
    if (!toneOut && last) hiLen <= cnt;
  end

  always @(posedge clock) begin
    if (toneOut && toneOutInv) clash <= 1'b1;
  end
endmodule // bde_piezo

// [testbench/testbench.sv]
// Purpose: Register-level bench for the buzzer duty and burst block
// Assumes: Divider shrunk to two clocks per tone grain
// Notes:   Tone lengths are read back from the piezo model
`timescale 1ns/100ps
module testbench;
  import bde_pkg::*;
  localparam int TD = 2;
  logic clock = 1'b0;
  logic sysRst = 1'b1;
  logic [ADDR_W-1:0] awAddr = '0;
  logic [ADDR_W-1:0] arAddr = '0;
  logic [31:0] wData = '0;
  logic [3:0] wStrb = '0;
  logic awValid = 1'b0;
  logic wValid = 1'b0;
  logic bReady = 1'b0;
  logic arValid = 1'b0;
  logic rReady = 1'b0;
  logic awReady, wReady, bValid, arReady, rValid, toneOut, toneInv;
  logic [1:0] bResp, rResp, resp;
  logic [31:0] rData, rdv;
  logic clash;
  int hiLen, perLen;
  int nMismatch = 0;
  int nTests = 0;

  // Free-running system clock
  always #2 clock = ~clock;

  bde_buzzer #(.TICK_DIV(TD)) i_dut (
    .clock(clock), .sys_rst(sysRst),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
    .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
    .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
    .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .tone_out(toneOut), .tone_out_inverted(toneInv)
  );

  bde_piezo i_piezo (
    .clock(clock), .toneOut(toneOut), .toneOutInv(toneInv),
    .hiLen(hiLen), .perLen(perLen), .clash(clash)
  );

  // Verdict and end of run
  task automatic end_sim();
    if (nMismatch == 0 && nTests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // One comparison
  task automatic chk(input string what, input logic [31:0] seen, exp);
    nTests++;
    if (seen !== exp) begin
      nMismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  // Bounded wait ran out
  task automatic tmo(input int n);
    if (n >= 100) begin
      nMismatch++;
      end_sim();
    end
  endtask

  // Register write, address and data offered together
  task automatic wr(input logic [15:0] idx, input logic [3:0] d,
                    input logic [3:0] st = 4'hf);
    int n;
    logic aw, w;
    @(posedge clock);
    awAddr <= {idx, 2'b00};
    wData <= {28'h0, d};
    wStrb <= st;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clock);
      if (bValid) begin
        resp = bResp;
        bReady <= 1'b0;
        break;
      end
      if (aw && awReady) begin
        awValid <= 1'b0;
        aw = 1'b0;
      end
      if (w && wReady) begin
        wValid <= 1'b0;
        w = 1'b0;
      end
    end
    tmo(n);
  endtask

  // Register read
  task automatic rd(input logic [15:0] idx);
    int n;
    logic ar;
    @(posedge clock);
    arAddr <= {idx, 2'b00};
    arValid <= 1'b1;
    rReady <= 1'b1;
    ar = 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clock);
      if (rValid) begin
        rdv = rData;
        resp = rResp;
        rReady <= 1'b0;
        break;
      end
      if (ar && arReady) begin
        arValid <= 1'b0;
        ar = 1'b0;
      end
    end
    tmo(n);
  endtask

  // Let some clocks pass
  task automatic pass(input int n);
    repeat (n) @(posedge clock);
  endtask

  // Main sequence
  initial begin
    int f, d, s;
    pass(16);
    sysRst <= 1'b0;
    for (f = 0; f < 4; f++) begin
      rd(IDX_ENV + 16'(f));
      chk("reset value", rdv, 32'h0);
    end
    wr(16'hff70, 4'h1);
    chk("unmapped bresp", resp, RESP_SLVERR);
    rd(16'hff70);
    chk("unmapped rresp", resp, RESP_SLVERR);
    // Write with byte lane 0 off leaves the register alone
    wr(IDX_FREQ, 4'h5, 4'h0);
    chk("no strobe bresp", resp, RESP_OKAY);
    rd(IDX_FREQ);
    chk("no strobe", rdv, 32'h0);
    // pin setup sits outside the block; pins taken as prepared
    // Every code and level on a continuous tone
    wr(IDX_ENV, 4'h1);
    for (f = 0; f < 8; f++) begin
      wr(IDX_FREQ, 4'(f));
      s = TD * (f > 3 ? 2 : 1);
      for (d = 0; d < 8; d++) begin
        wr(IDX_DUTY, 4'(d));
        pass(350);
        chk("period", perLen, (16 + 4 * (f % 4)) * s);
        chk("high", hiLen, ((f % 4 > 1 ? 12 : 8) - d) * s);
        chk("inverted", toneInv, !toneOut);
      end
    end
    wr(IDX_FREQ, 4'h0);
    wr(IDX_ENV, 4'h0);
    pass(20);
    chk("silent", {toneOut, toneInv}, 32'h0);
    // Envelope with duty field at minimum
    wr(IDX_ENV, 4'h3);
    pass(400);
    chk("env start", hiLen, 16);
    wr(IDX_DUTY, 4'h2);
    pass(9800);
    chk("env step short", hiLen, 14);
    wr(IDX_ENV, 4'h7);
    pass(400);
    chk("env restart", hiLen, 16);
    rd(IDX_ENV);
    chk("restart reads", rdv, 32'h3);
    wr(IDX_ENV, 4'hf);
    pass(10000);
    chk("env hold long", hiLen, 16);
    pass(7400);
    chk("env step long", hiLen, 14);
    wr(IDX_ENV, 4'h1);
    pass(400);
    chk("env off", hiLen, 12);
    wr(IDX_ENV, 4'h0);
    wr(IDX_DUTY, 4'h4);
    // Short burst and its end
    wr(IDX_SHOT, 4'h2);
    rd(IDX_SHOT);
    chk("busy", rdv, 32'h2);
    pass(400);
    chk("burst high", hiLen, 8);
    pass(3300);
    rd(IDX_SHOT);
    chk("short busy", rdv, 32'h2);
    pass(500);
    rd(IDX_SHOT);
    chk("short done", rdv, 32'h0);
    chk("burst off", {toneOut, toneInv}, 32'h0);
    // Retrigger extends the burst
    wr(IDX_SHOT, 4'h2);
    pass(3000);
    wr(IDX_SHOT, 4'h2);
    pass(3000);
    rd(IDX_SHOT);
    chk("extended", rdv, 32'h2);
    pass(1500);
    rd(IDX_SHOT);
    chk("extended end", rdv, 32'h0);
    // Early stop
    wr(IDX_SHOT, 4'h2);
    pass(100);
    wr(IDX_SHOT, 4'h4);
    rd(IDX_SHOT);
    chk("stopped", rdv, 32'h0);
    pass(20);
    chk("stop silent", {toneOut, toneInv}, 32'h0);
    // Long burst
    wr(IDX_SHOT, 4'h3);
    pass(8000);
    rd(IDX_SHOT);
    chk("long busy", rdv, 32'h3);
    pass(8800);
    rd(IDX_SHOT);
    chk("long done", rdv, 32'h1);
    // Trigger refused under continuous tone
    wr(IDX_ENV, 4'h1);
    wr(IDX_SHOT, 4'h2);
    rd(IDX_SHOT);
    chk("refused", rdv, 32'h0);
    wr(IDX_ENV, 4'h0);
    chk("pair overlap", clash, 32'h0);
    end_sim();
  end
endmodule // testbench
